// *** design/fss_regs.vh ***
// Constants of the flash self-programming sequencer
`ifndef FSS_REGS_VH
`define FSS_REGS_VH
`define FSS_OFS_CTRL 5'h00
`define FSS_OFS_PTR 5'h04
`define FSS_OFS_DATA 5'h08
`define FSS_OFS_STORE 5'h0C
`define FSS_OFS_LOAD 5'h10
`define FSS_OFS_LOCK 5'h14
`define FSS_CMD_FILL 5'h01
`define FSS_CMD_ERASE 5'h03
`define FSS_CMD_WRITE 5'h05
`define FSS_CMD_LOCK 5'h09
`define FSS_CMD_REEN 5'h11
`define FSS_BIT_EN 0
`define FSS_BIT_LOCK 3
`define FSS_BIT_IE 7
`define FSS_STORE_WIN 3'h4
`define FSS_LOAD_MIN 3'h2
`define FSS_PTR_LOCK 16'h0001
`define FSS_PTR_FLOW 16'h0000
`define FSS_PTR_FHIGH 16'h0003
`define FSS_FIRST_NO_READ_WHILE_WRITE_REGION_PAGE 7'h60
`define FSS_LOCK_RESET 8'hFF
`define FSS_OP_MIN_NS 3700000
`define FSS_CLK_NS 5
`endif

// *** design/fss_sequencer.v ***
// Flash self-programming sequencer with Avalon-MM register port
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "fss_regs.vh"
module fss_sequencer #(
    parameter OP_CYCLES = (`FSS_OP_MIN_NS + `FSS_CLK_NS - 1) / `FSS_CLK_NS
) (
    input wire ref_clk, // System clock, 200 MHz
    input wire arst_n, // Power-on reset, async, active low
    input wire sys_rst, // System reset, synchronous, active high
    input wire [4:0] address, // Avalon byte address
    input wire read, // Avalon read
    input wire write, // Avalon write
    input wire [3:0] byteenable, // Avalon byte enables
    input wire [31:0] writedata, // Avalon write data
    output reg [31:0] readdata, // Avalon read data
    output wire waitrequest, // Avalon wait request
    input wire eeprom_write_active_flag, // EEPROM write busy, pin
    input wire [7:0] fuse_low_byte, // Fuse low byte, pin
    input wire [7:0] fuse_high_byte, // Fuse high byte, pin
    input wire [7:0] flash_rd_data, // Flash byte at pointer
    input wire [4:0] buf_rd_word, // Page buffer read index
    output reg [15:0] buf_rd_data, // Page buffer word, FFFF if empty
    output reg flash_erase_start, // Pulse: begin page erase
    output reg flash_write_start, // Pulse: begin page write
    output reg [6:0] flash_page, // Latched page of the operation
    output wire flash_op_busy, // Timed flash operation running
    output wire rww_read_block, // Lower region blocked for reads
    output wire cpu_halt, // Processor halted
    output wire irq // Completion interrupt level
);
    localparam OP_W = 20;
    localparam [OP_W-1:0] OP_LOAD = OP_CYCLES[OP_W-1:0];
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_PAGE = 2'h1;
    localparam [1:0] ST_LOCK = 2'h2;

    reg ee_meta_reg;
    reg ee_sync_reg;
    reg ee_prev_reg;
    reg [7:0] flo_meta_reg;
    reg [7:0] flo_sync_reg;
    reg [7:0] fhi_meta_reg;
    reg [7:0] fhi_sync_reg;
    reg irq_en_reg;
    reg busy_flag_reg;
    reg [4:0] cmd_reg;
    reg [2:0] win_reg;
    reg [15:0] ptr_reg;
    reg [15:0] data_reg;
    reg [7:0] lock_reg;
    reg [1:0] state_reg;
    reg [OP_W-1:0] op_cnt_reg;
    reg op_no_read_while_write_region_reg;
    reg op_is_write_reg;
    reg op_done_reg;
    reg rd_pend_reg;
    reg [15:0] buf_mem [0:31];
    reg [31:0] buf_valid_reg;
    reg [31:0] rdata_next;

    wire armed = (win_reg != 3'h0);
    wire taken_wr = write && !waitrequest;
    wire first_rd = read && !rd_pend_reg && !cpu_halt;
    wire ctrl_wr = taken_wr && (address == `FSS_OFS_CTRL) && byteenable[0];
    wire store = taken_wr && (address == `FSS_OFS_STORE) && armed;
    wire load = first_rd && (address == `FSS_OFS_LOAD);
    wire [6:0] page_sel = ptr_reg[12:6];
    wire [4:0] word_sel = ptr_reg[5:1];
    wire page_is_no_read_while_write_region = (page_sel >= `FSS_FIRST_NO_READ_WHILE_WRITE_REGION_PAGE);
    wire readback_armed = (cmd_reg == `FSS_CMD_LOCK) &&
        (win_reg >= `FSS_LOAD_MIN) && !ee_sync_reg;
    wire cmd_ok = (writedata[4:0] == `FSS_CMD_FILL) ||
        (writedata[4:0] == `FSS_CMD_ERASE) ||
        (writedata[4:0] == `FSS_CMD_WRITE) ||
        (writedata[4:0] == `FSS_CMD_LOCK) ||
        (writedata[4:0] == `FSS_CMD_REEN);
    wire buf_clear = sys_rst || (op_done_reg && op_is_write_reg) ||
        (store && cmd_reg == `FSS_CMD_REEN) ||
        (ee_sync_reg && !ee_prev_reg && buf_valid_reg != 32'h0);
    wire buf_fill = store && (cmd_reg == `FSS_CMD_FILL) && !ee_sync_reg;
    // Last cycle of a timed operation
    wire op_last = flash_op_busy &&
        (op_cnt_reg == {{(OP_W-1){1'b0}}, 1'b1});

    assign flash_op_busy = (state_reg != ST_IDLE);
    assign rww_read_block = busy_flag_reg;
    assign cpu_halt = (state_reg == ST_PAGE) && op_no_read_while_write_region_reg;
    assign irq = irq_en_reg && !cmd_reg[`FSS_BIT_EN];
    // Reads take two cycles so that read data always come from a flop
    assign waitrequest = cpu_halt || (read && !rd_pend_reg);

    // Pins from outside the clock domain pass two flops
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ee_meta_reg <= 1'b0;
            ee_sync_reg <= 1'b0;
            ee_prev_reg <= 1'b0;
            flo_meta_reg <= 8'hFF;
            flo_sync_reg <= 8'hFF;
            fhi_meta_reg <= 8'hFF;
            fhi_sync_reg <= 8'hFF;
        end else begin
            ee_meta_reg <= eeprom_write_active_flag;
            ee_sync_reg <= ee_meta_reg;
            ee_prev_reg <= ee_sync_reg;
            flo_meta_reg <= fuse_low_byte;
            flo_sync_reg <= flo_meta_reg;
            fhi_meta_reg <= fuse_high_byte;
            fhi_sync_reg <= fhi_meta_reg;
        end
    end

    // Timed operation; sys_rst is ignored here so a running write finishes
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            op_cnt_reg <= {OP_W{1'b0}};
            op_no_read_while_write_region_reg <= 1'b0;
            op_is_write_reg <= 1'b0;
            op_done_reg <= 1'b0;
            flash_page <= 7'h00;
            flash_erase_start <= 1'b0;
            flash_write_start <= 1'b0;
        end else begin
            op_done_reg <= 1'b0;
            flash_erase_start <= 1'b0;
            flash_write_start <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (store && !ee_sync_reg) begin
                        if (cmd_reg == `FSS_CMD_ERASE ||
                            cmd_reg == `FSS_CMD_WRITE) begin
                            state_reg <= ST_PAGE;
                            op_cnt_reg <= OP_LOAD;
                            flash_page <= page_sel;
                            op_no_read_while_write_region_reg <= page_is_no_read_while_write_region;
                            op_is_write_reg <= (cmd_reg == `FSS_CMD_WRITE);
                            flash_erase_start <= (cmd_reg == `FSS_CMD_ERASE);
                            flash_write_start <= (cmd_reg == `FSS_CMD_WRITE);
                        end else if (cmd_reg == `FSS_CMD_LOCK) begin
                            state_reg <= ST_LOCK;
                            op_cnt_reg <= OP_LOAD;
                            op_no_read_while_write_region_reg <= 1'b0;
                            op_is_write_reg <= 1'b0;
                        end
                    end
                end
                ST_PAGE, ST_LOCK: begin
                    if (op_cnt_reg == {{(OP_W-1){1'b0}}, 1'b1}) begin
                        state_reg <= ST_IDLE;
                        op_done_reg <= 1'b1;
                    end
                    op_cnt_reg <= op_cnt_reg - {{(OP_W-1){1'b0}}, 1'b1};
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Control register, arming window and busy flag
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_en_reg <= 1'b0;
            busy_flag_reg <= 1'b0;
            cmd_reg <= 5'h00;
            win_reg <= 3'h0;
        end else if (sys_rst) begin
            irq_en_reg <= 1'b0;
            win_reg <= 3'h0;
            if (!flash_op_busy || op_last) begin
                cmd_reg <= 5'h00;
                busy_flag_reg <= 1'b0;
            end
        end else begin
            // Cleared on the closing edge so a halted processor resumes
            // and reads the operation as finished
            if (op_last) begin
                cmd_reg <= 5'h00;
            end else if (store) begin
                win_reg <= 3'h0;
                if (!ee_sync_reg && (cmd_reg == `FSS_CMD_ERASE ||
                    cmd_reg == `FSS_CMD_WRITE || cmd_reg == `FSS_CMD_LOCK)) begin
                    win_reg <= 3'h0;
                end else begin
                    cmd_reg <= 5'h00;
                end
                if (!ee_sync_reg && (cmd_reg == `FSS_CMD_ERASE ||
                    cmd_reg == `FSS_CMD_WRITE) && !page_is_no_read_while_write_region) begin
                    busy_flag_reg <= 1'b1;
                end else if (!ee_sync_reg && (cmd_reg == `FSS_CMD_FILL ||
                    cmd_reg == `FSS_CMD_REEN)) begin
                    busy_flag_reg <= 1'b0;
                end
            end else if (load && (cmd_reg == `FSS_CMD_LOCK) && armed) begin
                cmd_reg <= 5'h00;
                win_reg <= 3'h0;
            end else if (ctrl_wr) begin
                irq_en_reg <= writedata[`FSS_BIT_IE];
                if (cmd_ok && !flash_op_busy && !ee_sync_reg) begin
                    cmd_reg <= writedata[4:0];
                    win_reg <= `FSS_STORE_WIN;
                end
            end else if (armed) begin
                win_reg <= win_reg - 3'h1;
                if (win_reg == 3'h1 && !flash_op_busy) begin
                    cmd_reg <= 5'h00;
                end
            end
        end
    end

    // Pointer, data and lock byte; locks survive the system reset
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg <= 16'h0000;
            data_reg <= 16'h0000;
            lock_reg <= `FSS_LOCK_RESET;
        end else begin
            if (taken_wr && address == `FSS_OFS_PTR) begin
                if (byteenable[0]) ptr_reg[7:0] <= writedata[7:0];
                if (byteenable[1]) ptr_reg[15:8] <= writedata[15:8];
            end
            if (taken_wr && address == `FSS_OFS_DATA) begin
                if (byteenable[0]) data_reg[7:0] <= writedata[7:0];
                if (byteenable[1]) data_reg[15:8] <= writedata[15:8];
            end
            if (store && cmd_reg == `FSS_CMD_LOCK && !ee_sync_reg) begin
                // A zero programs a bit; programming never returns it to one
                lock_reg[5:2] <= lock_reg[5:2] & data_reg[5:2];
            end
        end
    end

    // Temporary page buffer, one entry per generate slice
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_buf
            always @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    buf_valid_reg[gi] <= 1'b0;
                end else if (buf_clear) begin
                    buf_valid_reg[gi] <= 1'b0;
                end else if (buf_fill && word_sel == gi) begin
                    buf_valid_reg[gi] <= 1'b1;
                end
            end
            always @(posedge ref_clk) begin
                if (buf_fill && !buf_clear && word_sel == gi) begin
                    buf_mem[gi] <= data_reg;
                end
            end
        end
    endgenerate

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_rd_data <= 16'hFFFF;
        end else if (buf_valid_reg[buf_rd_word]) begin
            buf_rd_data <= buf_mem[buf_rd_word];
        end else begin
            buf_rd_data <= 16'hFFFF;
        end
    end

    // Read multiplexer; fuse and lock readback keep zero as programmed
    always @* begin
        rdata_next = 32'h0000_0000;
        case (address)
            `FSS_OFS_CTRL: begin
                rdata_next[7:0] = {irq_en_reg, busy_flag_reg, 1'b0, cmd_reg};
            end
            `FSS_OFS_PTR: rdata_next[15:0] = ptr_reg;
            `FSS_OFS_DATA: rdata_next[15:0] = data_reg;
            `FSS_OFS_LOAD: begin
                rdata_next[7:0] = flash_rd_data;
                if (readback_armed) begin
                    if (ptr_reg == `FSS_PTR_LOCK) begin
                        rdata_next[7:0] = lock_reg;
                    end else if (ptr_reg == `FSS_PTR_FLOW) begin
                        rdata_next[7:0] = flo_sync_reg;
                    end else if (ptr_reg == `FSS_PTR_FHIGH) begin
                        rdata_next[7:0] = fhi_sync_reg;
                    end
                end
            end
            `FSS_OFS_LOCK: rdata_next[7:0] = lock_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata <= 32'h0000_0000;
            rd_pend_reg <= 1'b0;
        end else begin
            if (first_rd) begin
                readdata <= rdata_next;
                rd_pend_reg <= 1'b1;
            end else begin
                rd_pend_reg <= 1'b0;
            end
        end
    end
endmodule // fss_sequencer
`default_nettype wire

// *** verification/fss_monitor.sv ***
// Port-level assertions for the flash self-programming sequencer
`timescale 1ns/100ps
`default_nettype none
module fss_monitor #(
    parameter int OP_CYCLES = 20
) (
    input wire logic ref_clk, // Clock
    input wire logic arst_n, // Async reset, active low
    input wire logic read, // Avalon read
    input wire logic waitrequest, // Avalon wait request
    input wire logic flash_erase_start, // Erase pulse
    input wire logic flash_write_start, // Write pulse
    input wire logic flash_op_busy, // Timed operation running
    input wire logic rww_read_block, // Lower region blocked
    input wire logic cpu_halt, // Processor halted
    input wire logic irq // Completion interrupt
);
    int busy_cnt;
    // Counts busy cycles so the length check needs no long repetition
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            busy_cnt <= 0;
        else if (flash_op_busy)
            busy_cnt <= busy_cnt + 1;
        else
            busy_cnt <= 0;
    end
    default clocking mon_cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence op_start_s;
        flash_erase_start || flash_write_start;
    endsequence
    sequence one_side_s;
        flash_op_busy && (rww_read_block != cpu_halt);
    endsequence
    op_split_a: assert property (op_start_s |=> one_side_s)
        else $error("page op neither blocks nor halts, or both");
    op_length_a: assert property ($fell(flash_op_busy) |->
        busy_cnt >= OP_CYCLES - 1 && busy_cnt <= OP_CYCLES + 2)
        else $error("timed operation length off");
    no_restart_a: assert property (op_start_s |-> !$past(flash_op_busy))
        else $error("operation started while another ran");
    halt_wait_a: assert property (cpu_halt |-> waitrequest)
        else $error("bus answered while processor halted");
    op_irq_a: assert property (flash_op_busy && (cpu_halt || rww_read_block)
        |-> !irq)
        else $error("interrupt during page operation");
    halt_end_a: assert property ($fell(flash_op_busy) |-> !cpu_halt)
        else $error("halt outlives operation");
    read_wait_a: assert property ($rose(read) && !cpu_halt |->
        waitrequest ##1 !waitrequest)
        else $error("read answer timing wrong");
    pulse_one_a: assert property (op_start_s |=> !flash_erase_start
        && !flash_write_start)
        else $error("start pulse longer than a cycle");
endmodule // fss_monitor
bind fss_sequencer fss_monitor #(.OP_CYCLES(OP_CYCLES)) u_mon (
    .ref_clk(ref_clk), .arst_n(arst_n), .read(read),
    .waitrequest(waitrequest), .flash_erase_start(flash_erase_start),
    .flash_write_start(flash_write_start), .flash_op_busy(flash_op_busy),
    .rww_read_block(rww_read_block), .cpu_halt(cpu_halt), .irq(irq));
`default_nettype wire

// *** verification/fss_far_model.sv ***
// Far-side model: fuse pins, flash byte source and EEPROM busy pin
`timescale 1ns/100ps
`default_nettype none
module fss_far_model #(
    parameter logic [7:0] FUSE_LO = 8'hE1, // Arbitrary pattern
    parameter logic [7:0] FUSE_HI = 8'hD9 // Arbitrary pattern
) (
    input wire logic ref_clk, // Clock
    input wire logic ee_req, // Bench starts an EEPROM write
    input wire logic [6:0] flash_page, // Page under operation
    input wire logic flash_write_start, // Page write pulse
    output logic eeprom_write_active_flag, // EEPROM busy pin
    output logic [7:0] fuse_low_byte, // Zero bit means programmed
    output logic [7:0] fuse_high_byte, // Zero bit means programmed
    output logic [7:0] flash_rd_data // Byte for a plain load
);
    initial flash_rd_data = 8'h3C;
    assign fuse_low_byte = FUSE_LO;
    assign fuse_high_byte = FUSE_HI;
    // A written page changes the stored byte, so stale data shows up
    always @(posedge ref_clk) begin
        eeprom_write_active_flag <= ee_req;
        if (flash_write_start)
            flash_rd_data <= {1'h0, flash_page} ^ 8'hA5;
    end
endmodule // fss_far_model
`default_nettype wire

// *** verification/tb_flash_self_program_sequencer.sv ***
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_flash_self_program_sequencer;
    logic ref_clk = 0, arst_n, sys_rst, read, write, waitrequest, ee_req;
    logic ee_flag, es, ws, busy, blk, halt, irq;
    logic [4:0] address, buf_rd_word;
    logic [31:0] writedata, readdata, q;
    logic [7:0] f_lo, f_hi, f_rd;
    logic [15:0] buf_rd_data;
    logic [6:0] flash_page, page_seen;
    int n_fail = 0, n_compared = 0, n_starts = 0;
    always #2.5 ref_clk = ~ref_clk;
    fss_sequencer #(.OP_CYCLES(20)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .byteenable(4'h3), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .eeprom_write_active_flag(ee_flag),
        .fuse_low_byte(f_lo), .fuse_high_byte(f_hi), .flash_rd_data(f_rd),
        .buf_rd_word(buf_rd_word), .buf_rd_data(buf_rd_data),
        .flash_erase_start(es), .flash_write_start(ws),
        .flash_page(flash_page), .flash_op_busy(busy),
        .rww_read_block(blk), .cpu_halt(halt), .irq(irq));
    fss_far_model far (.ref_clk(ref_clk), .ee_req(ee_req),
        .flash_page(flash_page), .flash_write_start(ws),
        .eeprom_write_active_flag(ee_flag), .fuse_low_byte(f_lo),
        .fuse_high_byte(f_hi), .flash_rd_data(f_rd));
    // Start pulses last one cycle, so they are counted as they pass
    always @(posedge ref_clk) begin
        if (es || ws) begin
            n_starts <= n_starts + 1;
            page_seen <= flash_page;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, input bit hold);
        int i;
        write <= wr;
        read <= !wr;
        address <= a;
        writedata <= d;
        i = 0;
        // Sampled at the rising edge, before that edge's updates land
        do begin
            @(posedge ref_clk);
            i++;
        end while (waitrequest !== 1'h0 && i < 200);
        if (waitrequest !== 1'h0) begin
            n_fail++;
            give_verdict();
        end else begin
            q = readdata;
            // Held only when the next request must follow at once
            if (!hold) begin
                write <= 1'h0;
                read <= 1'h0;
                @(posedge ref_clk);
            end
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] p,
                       input logic [15:0] d);
        bus(1, 5'h04, {16'h0000, p}, 0);
        bus(1, 5'h08, {16'h0000, d}, 0);
        bus(1, 5'h00, {24'h000000, c}, 1);
        bus(1, 5'h0C, 32'h0, 0);
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 300 && busy !== 1'h0; i++) @(negedge ref_clk);
        if (i >= 300) begin
            n_fail++;
            give_verdict();
        end else
            @(posedge ref_clk);
    endtask
    task automatic readback(input logic [15:0] p, input logic [7:0] exp);
        bus(1, 5'h04, {16'h0000, p}, 0);
        bus(1, 5'h00, 32'h89, 1);
        bus(0, 5'h10, 32'h0, 0);
        chk(q, {24'h000000, exp});
    endtask
    task automatic t_fill();
        cmd(8'h01, 16'h0146, 16'h1234);
        buf_rd_word <= 5'h03;
        repeat (2) @(posedge ref_clk);
        chk(buf_rd_data, 16'h1234);
        ee_req <= 1'h1;
        repeat (6) @(posedge ref_clk);
        chk(buf_rd_data, 16'hFFFF);
        ee_req <= 1'h0;
        repeat (4) @(posedge ref_clk);
        cmd(8'h01, 16'h0146, 16'h5678);
        repeat (2) @(posedge ref_clk);
        chk(buf_rd_data, 16'h5678);
        $display("fill test done");
    endtask
    task automatic t_erase();
        bus(1, 5'h00, 32'h80, 0);
        cmd(8'h83, 16'h0140, 16'h0);
        @(posedge ref_clk);
        chk({blk, halt, page_seen}, {2'h2, 7'h05});
        bus(0, 5'h00, 32'h0, 0);
        chk(q, 32'hC3);
        wait_idle();
        bus(0, 5'h00, 32'h0, 0);
        chk({q[7:0], irq}, {8'hC0, 1'h1});
        cmd(8'h91, 16'h0, 16'h0);
        @(posedge ref_clk);
        chk({blk, buf_rd_data}, {1'h0, 16'hFFFF});
        $display("erase test done");
    endtask
    task automatic t_halt();
        buf_rd_word <= 5'h00;
        cmd(8'h81, 16'h1840, 16'hBEEF);
        cmd(8'h85, 16'h1840, 16'h0);
        chk({halt, blk, busy}, 3'h5);
        bus(0, 5'h00, 32'h0, 0);
        chk({q, halt, buf_rd_data}, {32'h80, 1'h0, 16'hFFFF});
        $display("halt test done");
    endtask
    task automatic t_lock();
        cmd(8'h89, 16'h0001, 16'h00EB);
        chk({busy, blk, halt}, 3'h4);
        wait_idle();
        bus(0, 5'h14, 32'h0, 0);
        chk(q, 32'hEB);
        readback(16'h0001, 8'hEB);
        readback(16'h0000, 8'hE1);
        readback(16'h0003, 8'hD9);
        bus(0, 5'h00, 32'h0, 0);
        chk(q, 32'h80);
        $display("lock test done");
    endtask
    task automatic t_refuse();
        int s;
        s = n_starts;
        bus(1, 5'h00, 32'h83, 0);
        repeat (4) @(posedge ref_clk);
        bus(1, 5'h0C, 32'h0, 0);
        bus(0, 5'h10, 32'h0, 0);
        chk(q, 32'hC4);
        cmd(8'h87, 16'h0140, 16'h0);
        ee_req <= 1'h1;
        repeat (4) @(posedge ref_clk);
        cmd(8'h83, 16'h0140, 16'h0);
        readback(16'h0001, 8'hC4);
        ee_req <= 1'h0;
        repeat (3) @(posedge ref_clk);
        chk({busy, n_starts[30:0]}, {1'h0, s[30:0]});
        $display("refusal test done");
    endtask
    task automatic t_sysrst();
        buf_rd_word <= 5'h03;
        cmd(8'h81, 16'h0146, 16'hA5A5);
        cmd(8'h83, 16'h0140, 16'h0);
        sys_rst <= 1'h1;
        @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(negedge ref_clk);
        chk(busy, 1'h1);
        wait_idle();
        bus(0, 5'h00, 32'h0, 0);
        chk({q[7:0], irq, buf_rd_data}, 32'h0080_FFFF);
        cmd(8'h11, 16'h0, 16'h0);
        chk(blk, 1'h0);
        $display("system reset test done");
    endtask
    initial begin
        arst_n = 0;
        sys_rst = 0;
        read = 0;
        write = 0;
        address = 0;
        writedata = 0;
        buf_rd_word = 0;
        ee_req = 0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        chk({irq, waitrequest, buf_rd_data}, {2'h0, 16'hFFFF});
        bus(0, 5'h14, 32'h0, 0);
        chk(q, 32'hFF);
        bus(0, 5'h1C, 32'h0, 0);
        chk(q, 32'h0);
        $display("reset test done");
        t_fill();
        t_erase();
        t_halt();
        t_lock();
        t_refuse();
        t_sysrst();
        give_verdict();
    end
endmodule // tb_flash_self_program_sequencer
`default_nettype wire
